// ==== aca_regs.svh ====
`ifndef ACA_REGS_SVH
`define ACA_REGS_SVH
`define ACA_CTRL 8'h00
`define ACA_START 8'h04
`define ACA_COND 8'h08
`define ACA_WIN 8'h0C
`define ACA_TOUT 8'h10
`define ACA_AUX 8'h14
`define ACA_STATUS 8'h18
`define ACA_LIVE 8'h1C
`define ACA_EVT_LO 8'h20
`define ACA_EVT_HI 8'h24
`define ACA_EVT_BYTES 8'h28
`define ACA_CTRL_RST 29'h0000_0000
`define ACA_START_RST 8'hFF
`define ACA_WIN_RST 16'h0032
`define ACA_TOUT_RST 16'h03E8
`define ACA_COND_REQ 7:0
`define ACA_COND_ANY 15:8
`define ACA_CLK_NS 20
`define ACA_LIVE_NS 1000000
`define ACA_FIFO_DEPTH 9'h140
`define ACA_FIFO_LAST 9'h13F
`define ACA_LAST_STEP 4'hD
`endif

// ==== aca_pkg.sv ====
package aca_pkg;
   typedef enum logic [1:0] {
      CO_IDLE = 2'b00,
      CO_WIN = 2'b01,
      CO_WAIT = 2'b11,
      CO_EMIT = 2'b10
   } aca_co_state_t;
   typedef enum logic [1:0] {SZ2 = 2'b00, SZ4 = 2'b01, SZ6 = 2'b10, SZ8 = 2'b11} aca_size_t;
   typedef struct packed {
      aca_size_t size;
      logic [63:0] data;
   } aca_entry_t;
   typedef struct packed {
      logic co_swp;
      logic co_cnt;
      logic co_rtc;
      logic tag_swp;
      logic tag_rtc;
      logic [7:0] rise;
      logic [7:0] coi_en;
      logic [7:0] sgl_en;
   } aca_ctrl_t;
endpackage

// ==== aca_fifo.sv ====
`timescale 1ns/1ns
`include "aca_regs.svh"

module aca_fifo import aca_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Fill side
   input wire aca_entry_t in_entry,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output aca_entry_t out_entry,
   output logic out_valid,
   input wire logic out_ready,
   output logic [8:0] level
);
   aca_entry_t mem [320];
   logic [8:0] wp;
   logic [8:0] rp;
   logic push;
   logic pop;

   assign in_ready = level != `ACA_FIFO_DEPTH;
   assign out_valid = level != 9'h000;
   assign out_entry = mem[rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_entry;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wp <= 9'h000;
         rp <= 9'h000;
         level <= 9'h000;
      end else begin
         if (push) begin
            wp <= (wp == `ACA_FIFO_LAST) ? 9'h000 : wp + 9'h001;
         end
         if (pop) begin
            rp <= (rp == `ACA_FIFO_LAST) ? 9'h000 : rp + 9'h001;
         end
         level <= level + {8'h00, push} - {8'h00, pop};
      end
   end
endmodule

// ==== aca_top.sv ====
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "aca_regs.svh"

module aca_top import aca_pkg::*; #(
   parameter int LIVE_CYCLES = `ACA_LIVE_NS / `ACA_CLK_NS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Converter ports
   input wire logic [7:0] busy_pin,
   input wire logic [7:0] word_valid_request,
   input wire logic [7:0][15:0] port_data,
   output logic [7:0] word_taken_ack,
   // Sweep and counter values from the timing section
   input wire logic sweep_active,
   input wire logic [47:0] sweep_count,
   input wire logic [31:0] cnt1,
   input wire logic [31:0] cnt3,
   input wire logic [31:0] cnt4,
   // Auxiliary outputs
   output logic [2:0] aux_out
);
   aca_ctrl_t ctrl;
   logic [7:0] start_mask;
   logic [15:0] cond;
   logic [15:0] win_len;
   logic [15:0] timeout;
   logic [5:0] aux_sel;
   logic resp;
   logic [31:0] next_rdata;
   logic [7:0] busy_s1, busy_s2, busy_s3, req_s1, req_s2;
   logic [7:0][15:0] pd_s1, pd_s2, hold;
   logic [7:0][31:0] rtc_cap;
   logic [7:0][8:0] swp_cap;
   logic [7:0] act, ack, latch_go, sgl_pend, sgl_pop, got, part, live;
   logic [47:0] rtc, co_rtc, co_swp;
   logic [31:0] co_c1, co_c3, co_c4, tick_cnt;
   aca_co_state_t co_st;
   logic [15:0] win_cnt, to_cnt;
   logic [3:0] step;
   logic [2:0] pi, sel;
   logic need, emit, cond_ok, g1, grp, sgl_any, tick, live_new;
   aca_entry_t e_ent, s_ent, fifo_in, fifo_out;
   logic fifo_wr, fifo_ready, fifo_ovalid, fifo_pop, fifo_full;
   logic [8:0] fifo_level;
   logic [3:0] bytes;
   logic [3:0] aux_src;

   assign word_taken_ack = ack;

   // Pins are asynchronous; data is stable while the request is held
   always_ff @(posedge clk) begin
      if (!rstn) begin
         busy_s1 <= 8'h00;
         busy_s2 <= 8'h00;
         busy_s3 <= 8'h00;
         req_s1 <= 8'h00;
         req_s2 <= 8'h00;
         pd_s1 <= '0;
         pd_s2 <= '0;
      end else begin
         busy_s1 <= busy_pin;
         busy_s2 <= busy_s1;
         busy_s3 <= busy_s2;
         req_s1 <= word_valid_request;
         req_s2 <= req_s1;
         pd_s1 <= port_data;
         pd_s2 <= pd_s1;
      end
   end

   assign act = (busy_s2 ^ busy_s3) & ~(busy_s2 ^ ctrl.rise);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rtc <= 48'h0000_0000_0000;
      end else begin
         rtc <= rtc + 48'h0000_0000_0001;
      end
   end

   for (genvar i = 0; i < 8; i++) begin : g_port
      logic win_ok;
      // Coincidence-only ports stay deaf outside processing
      assign win_ok = ctrl.coi_en[i] && (co_st == CO_WIN || co_st == CO_WAIT) && !got[i];
      assign latch_go[i] = !ack[i] && req_s2[i] && sweep_active && fifo_ready
         && !sgl_pend[i] && !(got[i] && part[i]) && (ctrl.sgl_en[i] || win_ok);

      always_ff @(posedge clk) begin
         if (!rstn) begin
            ack[i] <= 1'b0;
            sgl_pend[i] <= 1'b0;
            hold[i] <= 16'h0000;
            swp_cap[i] <= 9'h000;
         end else if (latch_go[i]) begin
            hold[i] <= pd_s2[i];
            swp_cap[i] <= sweep_count[8:0];
            ack[i] <= 1'b1;
            sgl_pend[i] <= ctrl.sgl_en[i];
         end else begin
            if (ack[i] && !req_s2[i]) begin
               ack[i] <= 1'b0;
            end
            if (sgl_pop[i]) begin
               sgl_pend[i] <= 1'b0;
            end
         end
      end

      always_ff @(posedge clk) begin
         if (!rstn) begin
            rtc_cap[i] <= 32'h0000_0000;
         end else if (act[i]) begin
            rtc_cap[i] <= rtc[31:0];
         end
      end
   end

   function automatic logic [1:0] low4(input logic [3:0] v);
      low4 = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
   endfunction

   // Two port groups share one event queue, served alternately so neither group starves
   always_comb begin
      sgl_any = |sgl_pend;
      g1 = (|sgl_pend[7:4]) && (!(|sgl_pend[3:0]) || grp);
      sel = g1 ? {1'b1, low4(sgl_pend[7:4])} : {1'b0, low4(sgl_pend[3:0])};
      s_ent.data[31:0] = {3'h0, ctrl.tag_swp ? swp_cap[sel] : 9'h000, 1'b0, sel, hold[sel]};
      s_ent.data[63:32] = ctrl.tag_rtc ? rtc_cap[sel] : 32'h0000_0000;
      s_ent.size = ctrl.tag_rtc ? SZ8 : SZ4;
   end

   always_comb begin
      pi = 3'(step - 4'h6);
      need = 1'b1;
      e_ent.size = SZ4;
      e_ent.data = 64'h0;
      case (step)
         4'h0: begin
            e_ent.data[31:0] = {1'b1, 7'h00, got & part, part, 8'h00};
         end
         4'h1: begin
            need = ctrl.co_rtc;
            e_ent.size = SZ6;
            e_ent.data[47:0] = co_rtc;
         end
         4'h2: begin
            need = ctrl.co_cnt;
            e_ent.data[31:0] = co_c1;
         end
         4'h3: begin
            need = ctrl.co_cnt;
            e_ent.data[31:0] = co_c3;
         end
         4'h4: begin
            need = ctrl.co_cnt;
            e_ent.data[31:0] = co_c4;
         end
         4'h5: begin
            need = ctrl.co_swp;
            e_ent.size = SZ6;
            e_ent.data[47:0] = co_swp;
         end
         default: begin
            need = part[pi];
            e_ent.size = SZ2;
            e_ent.data[15:0] = got[pi] ? hold[pi] : 16'h0000;
         end
      endcase
   end

   assign emit = co_st == CO_EMIT;
   assign fifo_in = emit ? e_ent : s_ent;
   assign fifo_wr = emit ? need : sgl_any;
   assign fifo_full = !fifo_ready;
   assign sgl_pop = (!emit && sgl_any && fifo_ready) ? 8'(8'h01 << sel) : 8'h00;
   assign cond_ok = ((part & cond[`ACA_COND_REQ]) == cond[`ACA_COND_REQ])
      && (cond[`ACA_COND_ANY] == 8'h00 || (|(part & cond[`ACA_COND_ANY])));

   always_ff @(posedge clk) begin
      if (!rstn) begin
         grp <= 1'b0;
      end else if (|sgl_pop) begin
         grp <= !g1;
      end
   end

   aca_fifo u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_entry(fifo_in),
      .in_valid(fifo_wr),
      .in_ready(fifo_ready),
      .out_entry(fifo_out),
      .out_valid(fifo_ovalid),
      .out_ready(fifo_pop),
      .level(fifo_level)
   );

   always_ff @(posedge clk) begin
      if (!rstn) begin
         co_st <= CO_IDLE;
         part <= 8'h00;
         got <= 8'h00;
         win_cnt <= 16'h0000;
         to_cnt <= 16'h0000;
         step <= 4'h0;
         co_rtc <= 48'h0000_0000_0000;
         co_swp <= 48'h0000_0000_0000;
         co_c1 <= 32'h0000_0000;
         co_c3 <= 32'h0000_0000;
         co_c4 <= 32'h0000_0000;
      end else begin
         case (co_st)
            CO_IDLE: begin
               if (|(act & ctrl.coi_en & start_mask)) begin
                  part <= act & ctrl.coi_en;
                  co_rtc <= rtc;
                  co_swp <= sweep_count;
                  co_c1 <= cnt1;
                  co_c3 <= cnt3;
                  co_c4 <= cnt4;
                  win_cnt <= win_len;
                  co_st <= CO_WIN;
               end
            end
            CO_WIN: begin
               part <= part | (act & ctrl.coi_en);
               got <= got | (latch_go & ctrl.coi_en);
               if (win_cnt == 16'h0000) begin
                  to_cnt <= timeout;
                  co_st <= CO_WAIT;
               end else begin
                  win_cnt <= win_cnt - 16'h0001;
               end
            end
            CO_WAIT: begin
               got <= got | (latch_go & ctrl.coi_en);
               if ((got & part) == part || to_cnt == 16'h0000) begin
                  step <= 4'h0;
                  if (cond_ok) begin
                     co_st <= CO_EMIT;
                  end else begin
                     part <= 8'h00;
                     got <= 8'h00;
                     co_st <= CO_IDLE;
                  end
               end else begin
                  to_cnt <= to_cnt - 16'h0001;
               end
            end
            CO_EMIT: begin
               if (!need || fifo_ready) begin
                  if (step == `ACA_LAST_STEP) begin
                     part <= 8'h00;
                     got <= 8'h00;
                     co_st <= CO_IDLE;
                  end else begin
                     step <= step + 4'h1;
                  end
               end
            end
            default: co_st <= CO_IDLE;
         endcase
      end
   end

   assign tick = tick_cnt == 32'(LIVE_CYCLES - 1);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tick_cnt <= 32'h0000_0000;
         live <= 8'h00;
         live_new <= 1'b0;
      end else begin
         tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
         if (tick) begin
            live <= busy_s2;
         end
         // New sample wins over a clearing read
         if (tick) begin
            live_new <= 1'b1;
         end else if (read && resp && address == `ACA_LIVE) begin
            live_new <= 1'b0;
         end
      end
   end

   assign aux_src = {|act, emit, co_st == CO_WAIT, co_st == CO_WIN};

   for (genvar k = 0; k < 3; k++) begin : g_aux
      always_ff @(posedge clk) begin
         if (!rstn) begin
            aux_out[k] <= 1'b0;
         end else begin
            aux_out[k] <= aux_src[aux_sel[2*k +: 2]];
         end
      end
   end

   // One wait state per access keeps read data registered
   assign waitrequest = (read || write) && !resp;
   assign fifo_pop = read && resp && address == `ACA_EVT_HI && fifo_ovalid;
   assign bytes = {1'b0, fifo_out.size, 1'b0} + 4'h2;

   always_comb begin
      case (address)
         `ACA_CTRL: next_rdata = {3'h0, ctrl};
         `ACA_START: next_rdata = {24'h00_0000, start_mask};
         `ACA_COND: next_rdata = {16'h0000, cond};
         `ACA_WIN: next_rdata = {16'h0000, win_len};
         `ACA_TOUT: next_rdata = {16'h0000, timeout};
         `ACA_AUX: next_rdata = {26'h000_0000, aux_sel};
         `ACA_STATUS: next_rdata = {19'h0_0000, live_new, fifo_level, co_st, fifo_full};
         `ACA_LIVE: next_rdata = {24'h00_0000, live};
         `ACA_EVT_LO: next_rdata = fifo_ovalid ? fifo_out.data[31:0] : 32'h0000_0000;
         `ACA_EVT_HI: next_rdata = fifo_ovalid ? fifo_out.data[63:32] : 32'h0000_0000;
         // Empty queue shows no size, never a stale head entry
         `ACA_EVT_BYTES: next_rdata = {27'h000_0000, fifo_ovalid, fifo_ovalid ? bytes : 4'h0};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         resp <= 1'b0;
         readdata <= 32'h0000_0000;
      end else begin
         resp <= (read || write) && !resp;
         if (read && !resp) begin
            readdata <= next_rdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl <= `ACA_CTRL_RST;
         start_mask <= `ACA_START_RST;
         cond <= 16'h0000;
         win_len <= `ACA_WIN_RST;
         timeout <= `ACA_TOUT_RST;
         aux_sel <= 6'h00;
      end else if (write && resp) begin
         case (address)
            `ACA_CTRL: ctrl <= writedata[28:0];
            `ACA_START: start_mask <= writedata[7:0];
            `ACA_COND: cond <= writedata[15:0];
            `ACA_WIN: win_len <= writedata[15:0];
            `ACA_TOUT: timeout <= writedata[15:0];
            `ACA_AUX: aux_sel <= writedata[5:0];
            default: ;
         endcase
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   ack_hold_a: assert property ((|(ack & req_s2)) |=> (($past(ack & req_s2) & ~ack) == 8'h00))
      else $error("ack dropped while request held");
   ack_drop_a: assert property ((|(ack & ~req_s2)) |=> (($past(ack & ~req_s2) & ack) == 8'h00))
      else $error("ack kept after request removed");
   sweep_gate_a: assert property (((ack & ~$past(ack)) != 8'h00) |-> $past(sweep_active))
      else $error("data taken outside active sweep");
   coinc_only_a: assert property (((ack & ~$past(ack) & $past(ctrl.coi_en & ~ctrl.sgl_en)) != 8'h00)
      |-> ($past(co_st) == CO_WIN || $past(co_st) == CO_WAIT))
      else $error("coincidence port took data outside window");
   full_stop_a: assert property ($past(fifo_full) |-> ((ack & ~$past(ack)) == 8'h00))
      else $error("data taken while event fifo full");
   win_open_a: assert property ((co_st == CO_IDLE && (|(act & ctrl.coi_en & start_mask)))
      |=> (co_st == CO_WIN && win_cnt == $past(win_len)))
      else $error("window not opened on start edge");
   no_open_a: assert property ((co_st == CO_IDLE && !(|(act & ctrl.coi_en & start_mask)))
      |=> co_st == CO_IDLE)
      else $error("window opened by masked port");
   win_close_a: assert property ((co_st == CO_WIN && win_cnt == 16'h0000)
      |=> (co_st == CO_WAIT && to_cnt == $past(timeout)))
      else $error("wait phase not entered at window end");
   timeout_a: assert property ((co_st == CO_WAIT && to_cnt == 16'h0000) |=> co_st != CO_WAIT)
      else $error("wait outlived timeout");
   zero_fill_a: assert property ((emit && step >= 4'h6 && fifo_wr && !got[pi])
      |-> fifo_in.data == 64'h0)
      else $error("missing port not zero filled");
   live_a: assert property (tick |=> live == $past(busy_s2))
      else $error("busy sample not taken at tick");
   rtc_cap_a: assert property (act[0] |=> rtc_cap[0] == $past(rtc[31:0]))
      else $error("real time not captured on edge");
   reset_a: assert property (@(posedge clk) disable iff (1'b0)
      !rstn |=> (co_st == CO_IDLE && part == 8'h00 && got == 8'h00))
      else $error("reset left coincidence state");
endmodule

// ==== aca_conv_model.sv ====
`timescale 1ns/1ns

module aca_conv_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Commands from the bench
   input wire logic [7:0] go,
   input wire logic [7:0][15:0] value,
   input wire logic [7:0] slow,
   // Converter port pins
   input wire logic [7:0] word_taken_ack,
   output logic [7:0] word_valid_request,
   output logic [7:0][15:0] port_data,
   output logic [7:0] idle
);
   logic [1:0] st [8];
   logic [3:0] hold [8];

   always_comb begin
      for (int p = 0; p < 8; p++) begin
         idle[p] = (st[p] == 2'd0);
      end
   end

   always_ff @(posedge clk) begin
      for (int p = 0; p < 8; p++) begin
         if (!rstn) begin
            st[p] <= 2'd0;
            hold[p] <= 4'h0;
            word_valid_request[p] <= 1'b0;
            port_data[p] <= 16'h5A5A;
         end else begin
            case (st[p])
               2'd0: begin
                  if (go[p]) begin
                     port_data[p] <= value[p];
                     word_valid_request[p] <= 1'b1;
                     hold[p] <= 4'h0;
                     st[p] <= 2'd1;
                  end else begin
                     // Released bus toggles so no stale word can pass
                     port_data[p] <= ~port_data[p];
                  end
               end
               2'd1: begin
                  if (word_taken_ack[p]) begin
                     hold[p] <= hold[p] + 4'h1;
                     // Slow converter keeps its request up a while
                     if (!slow[p] || hold[p] == 4'hF) begin
                        word_valid_request[p] <= 1'b0;
                        port_data[p] <= ~port_data[p];
                        st[p] <= 2'd2;
                     end
                  end
               end
               default: begin
                  if (!word_taken_ack[p]) begin
                     st[p] <= 2'd0;
                  end
               end
            endcase
         end
      end
   end
endmodule

// ==== aca_top_bench.sv ====
`timescale 1ns/1ns
`include "aca_regs.svh"

module aca_top_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [7:0] busy_pin = 8'h00;
   logic [7:0] word_valid_request;
   logic [7:0][15:0] port_data;
   logic [7:0] word_taken_ack;
   logic sweep_active = 1'b1;
   logic [2:0] aux_out;
   logic [7:0] go = 8'h00;
   logic [7:0][15:0] value = '0;
   logic [7:0] slow = 8'h00;
   logic [7:0] idle;
   logic [31:0] d;
   int bad_count = 0;
   int check_count = 0;

   always #10 clk = ~clk;

   aca_top #(.LIVE_CYCLES(20)) i_dut (
      .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .busy_pin(busy_pin), .word_valid_request(word_valid_request),
      .port_data(port_data), .word_taken_ack(word_taken_ack),
      .sweep_active(sweep_active), .sweep_count(48'h0000_0000_01A5),
      .cnt1(32'h1111_1111), .cnt3(32'h3333_3333), .cnt4(32'h4444_4444),
      .aux_out(aux_out));

   aca_conv_model i_conv (
      .clk(clk), .rstn(rstn), .go(go), .value(value), .slow(slow),
      .word_taken_ack(word_taken_ack), .word_valid_request(word_valid_request),
      .port_data(port_data), .idle(idle));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Mismatches %0d in %0d checks", bad_count, check_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Request stands until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      address <= a;
      writedata <= wd;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // One idle edge so the next call never reassigns a strobe in this step
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic send(input logic [7:0] ports, input logic [15:0] v);
      for (int p = 0; p < 8; p++) value[p] <= v + 16'(p);
      go <= ports;
      @(posedge clk);
      go <= 8'h00;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      while (idle !== 8'hFF && n < 100) begin
         @(posedge clk);
         n++;
      end
      repeat (2) @(posedge clk);
      check(32'(n < 100), 32'h1);
   endtask

   task automatic quiet(input logic [7:0] ports);
      logic seen;
      seen = 1'b0;
      repeat (20) begin
         @(negedge clk);
         if ((word_taken_ack & ports) !== 8'h00) seen = 1'b1;
      end
      @(posedge clk);
      check(32'(seen), 32'h0);
   endtask

   task automatic t_reset();
      rd(`ACA_CTRL);
      check(d, 32'h0);
      rd(`ACA_START);
      check(d, 32'h0000_00FF);
      rd(`ACA_WIN);
      check(d, 32'h0000_0032);
      rd(`ACA_TOUT);
      check(d, 32'h0000_03E8);
      rd(`ACA_STATUS);
      check(d, 32'h0);
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40);
      check(d, 32'h0);
   endtask

   task automatic t_live();
      busy_pin <= 8'hA5;
      repeat (50) @(posedge clk);
      rd(`ACA_LIVE);
      check(32'(d[7:0]), 32'h0000_00A5);
      busy_pin <= 8'h00;
      repeat (50) @(posedge clk);
   endtask

   task automatic t_single();
      int n;
      wr(`ACA_CTRL, 32'h0300_0004);
      sweep_active <= 1'b0;
      send(8'h04, 16'hBEEF);
      quiet(8'h04);
      rd(`ACA_EVT_BYTES);
      check(d, 32'h0);
      sweep_active <= 1'b1;
      wait_idle();
      rd(`ACA_EVT_BYTES);
      check(d, 32'h0000_0018);
      rd(`ACA_EVT_LO);
      check(d, {3'b000, 9'h1A5, 1'b0, 3'd2, 16'hBEF1});
      rd(`ACA_EVT_HI);
      wr(`ACA_CTRL, 32'h0000_0004);
      send(8'h04, 16'h7000);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (word_taken_ack[2] !== 1'b1 && n < 20);
      @(posedge clk);
      check(32'(n), 32'h4);
      wait_idle();
      rd(`ACA_EVT_BYTES);
      check(d, 32'h0000_0014);
      rd(`ACA_EVT_LO);
      check(d, 32'h0002_7002);
      rd(`ACA_EVT_HI);
      check(d, 32'h0);
   endtask

   task automatic t_coinc();
      int n;
      wr(`ACA_CTRL, 32'h0020_6000);
      wr(`ACA_START, 32'h0000_0020);
      wr(`ACA_WIN, 32'h0000_0014);
      wr(`ACA_TOUT, 32'h0000_0028);
      wr(`ACA_AUX, 32'h0);
      send(8'h20, 16'h1230);
      quiet(8'h20);
      busy_pin <= 8'h40;
      repeat (3) @(posedge clk);
      busy_pin <= 8'h00;
      repeat (6) @(posedge clk);
      rd(`ACA_STATUS);
      check(32'(d[2:1]), 32'h0);
      busy_pin <= 8'h20;
      repeat (2) @(posedge clk);
      busy_pin <= 8'h60;
      repeat (2) @(posedge clk);
      busy_pin <= 8'h20;
      repeat (2) @(posedge clk);
      check(32'(aux_out[0]), 32'h1);
      rd(`ACA_STATUS);
      check(32'(d[2:1]), 32'h1);
      busy_pin <= 8'h00;
      n = 0;
      do begin
         rd(`ACA_STATUS);
         n++;
      end while (d[2:1] !== 2'b00 && n < 100);
      check(32'(n < 100), 32'h1);
      rd(`ACA_EVT_BYTES);
      check(d, 32'h0000_0014);
      rd(`ACA_EVT_LO);
      check(d, 32'h8020_6000);
      rd(`ACA_EVT_HI);
      rd(`ACA_EVT_BYTES);
      check(d, 32'h0000_0012);
      rd(`ACA_EVT_LO);
      check(32'(d[15:0]), 32'h0000_1235);
      rd(`ACA_EVT_HI);
      rd(`ACA_EVT_LO);
      check(32'(d[15:0]), 32'h0);
      rd(`ACA_EVT_HI);
      rd(`ACA_EVT_BYTES);
      check(d, 32'h0);
   endtask

   task automatic t_full();
      wr(`ACA_CTRL, 32'h0000_0011);
      slow <= 8'h10;
      for (int i = 0; i < 160; i++) begin
         send(8'h11, 16'(i));
         wait_idle();
      end
      rd(`ACA_STATUS);
      check(32'({d[11:3], d[0]}), 32'h0000_0281);
      send(8'h01, 16'h0);
      quiet(8'h01);
      rd(`ACA_EVT_HI);
      wait_idle();
      rd(`ACA_STATUS);
      check(32'({d[11:3], d[0]}), 32'h0000_0281);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_live();
      t_single();
      t_coinc();
      t_full();
      finish_test();
   end
endmodule
